// *** cpd_cfg.svh ***
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH

// register byte offsets
`define CPD_OFF_CTRL_WORD    8'h00
`define CPD_OFF_ERR_INFO     8'h04
`define CPD_OFF_STATUS       8'h08
`define CPD_OFF_RECORD_SEL   8'h0C
`define CPD_OFF_TEST_FAULT   8'h10
`define CPD_OFF_DIR_VALID    8'h14
`define CPD_OFF_PARAM_OK     8'h18
`define CPD_OFF_ACTION       8'h1C
`define CPD_OFF_LIST_TRACE   8'h20

// command codes, upper byte of the control word
`define CPD_CMD_STORE        8'h72
`define CPD_CMD_RESTORE      8'h73
`define CPD_CMD_DEFAULTS     8'h74
`define CPD_CMD_FAST_REPARAM 8'h75
`define CPD_CMD_READ_BACK    8'h76
`define CPD_CMD_WRITE_REGS   8'h77
`define CPD_CMD_SELF_TEST    8'h81
`define CPD_CMD_RUN_LISTS    8'h82
`define CPD_CMD_READ_SERIES  8'h83

// error codes
`define CPD_ERR_NONE         8'h00
`define CPD_ERR_TEST_BITS    8'h01
`define CPD_ERR_NO_SEL       8'h03
`define CPD_ERR_TEST_BASE    8'h05
`define CPD_ERR_RECORD       8'h50
`define CPD_ERR_DIR_BASE     8'h40

// counter test setup and highest record number
`define CPD_TEST_LOAD_VALUE  16'hFFFF
`define CPD_MAX_RECORD       8'h07

// status register bit positions
`define CPD_ST_BUSY          0
`define CPD_ST_GREEN         1
`define CPD_ST_RED           2
`define CPD_ST_GROUP_ERR     3
`define CPD_ST_RUN_FLASH     4

// run indicator flash half period
`define CPD_FLASH_MS         250
`define CPD_CLK_HZ           10000000
`define CPD_FLASH_CYCLES     ((`CPD_FLASH_MS * (`CPD_CLK_HZ / 1000)))

`endif

// *** cpd_decoder.sv ***
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`include "cpd_cfg.svh"
module cpd_decoder import cpd_pkg::*; #(
    parameter int unsigned FLASH_CYCLES = `CPD_FLASH_CYCLES,
    parameter bit          EXTENDED     = 1'b1
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic [4:0]  i_test_fail,
    input  wire logic        i_in_list,
    output logic             o_led_green,
    output logic             o_led_red,
    output logic [15:0]      o_test_load_value,
    output logic             o_test_count_down
);
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_LISTS} cpd_state_t;

    cpd_state_t     state_reg, state_next;
    cpd_ctrl_word_t cw_reg;
    cpd_action_t    action_reg, action_next;
    logic [7:0]     err_reg, err_next;
    logic [7:0]     rec_sel_reg;
    logic [7:0]     rec_stored_reg, rec_stored_next;
    logic [4:0]     test_fault_reg, test_fault_next;
    logic [7:0]     dir_valid_reg;
    logic [7:0]     param_ok_reg, param_ok_next;
    logic [7:0]     list_pend_reg, list_pend_next;
    logic [7:0]     list_trace_reg, list_trace_next;
    logic           group_err_reg, group_err_next;
    logic           green_reg, red_reg, red_next;
    logic           ack_reg;
    logic           fast_reg, fast_next;

    // decode of bus requests
    wire        req      = i_avs_read | i_avs_write;
    wire        wr_ctrl  = i_avs_write & (i_avs_address == `CPD_OFF_CTRL_WORD) & ~ack_reg;
    wire        wr_rec   = i_avs_write & (i_avs_address == `CPD_OFF_RECORD_SEL) & ~ack_reg;
    wire        wr_dir   = i_avs_write & (i_avs_address == `CPD_OFF_DIR_VALID) & ~ack_reg;
    wire        wr_err   = i_avs_write & (i_avs_address == `CPD_OFF_ERR_INFO) & ~ack_reg;
    wire        busy     = (state_reg != ST_IDLE);
    // a new control word waits while one is still running
    wire        ctrl_hold = wr_ctrl & busy;
    wire        new_cmd  = wr_ctrl & ~busy & i_avs_byteenable[0] & i_avs_byteenable[1];
    wire [7:0]  code     = cw_reg.code;
    wire [7:0]  sel      = cw_reg.sel;
    wire        sel_none = (sel == 8'h00);
    wire        rec_bad  = EXTENDED ? (rec_sel_reg > `CPD_MAX_RECORD)
                                    : (rec_sel_reg != 8'h00);
    wire [2:0]  rec_idx  = rec_sel_reg[2:0];
    wire        rec_empty = ~rec_stored_reg[rec_idx];
    wire [4:0]  test_hit = sel[4:0] & i_test_fail;
    wire [7:0]  dir_miss = sel & ~dir_valid_reg & 8'hFE;
    wire [7:0]  list_low = list_pend_reg & (~list_pend_reg + 8'h01);
    wire        flash_tick;
    wire        params_good = param_ok_reg[0] & (|param_ok_reg[7:1]);
    wire [4:0]  status_bits = {~params_good, group_err_reg, red_reg,
                               green_reg, busy};
    // take is the first edge of a request; the answer follows one cycle later
    wire        take     = req & ~ack_reg;
    wire        rd_take  = i_avs_read & ~ack_reg;

    logic [7:0] dir_first;
    logic [7:0] test_code;
    always_comb begin
        dir_first = 8'h00;
        for (int i = 7; i >= 1; i--) begin
            if (dir_miss[i]) begin
                dir_first = `CPD_ERR_DIR_BASE + 8'(i);
            end
        end
        test_code = 8'h00;
        for (int i = 4; i >= 0; i--) begin
            if (test_hit[i]) begin
                test_code = `CPD_ERR_TEST_BASE + 8'(i);
            end
        end
    end

    always_comb begin
        state_next      = state_reg;
        action_next     = CPD_ACT_NONE;
        err_next        = wr_err ? i_avs_writedata[7:0] : err_reg;
        rec_stored_next = rec_stored_reg;
        test_fault_next = test_fault_reg;
        param_ok_next   = param_ok_reg;
        list_pend_next  = list_pend_reg;
        list_trace_next = list_trace_reg;
        group_err_next  = group_err_reg;
        red_next        = red_reg;
        fast_next       = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (new_cmd) begin
                    state_next = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_next = ST_IDLE;
                case (code)
                    `CPD_CMD_STORE: begin
                        if (sel_none) begin
                            err_next = `CPD_ERR_NO_SEL;
                        end else if (rec_bad) begin
                            err_next = `CPD_ERR_RECORD;
                        end else begin
                            // pointer word to series block excluded from record
                            rec_stored_next[rec_idx] = 1'b1;
                            action_next = CPD_ACT_STORE;
                        end
                    end
                    `CPD_CMD_RESTORE: begin
                        if (sel_none) begin
                            err_next = `CPD_ERR_NO_SEL;
                        end else if (rec_bad || rec_empty) begin
                            err_next = `CPD_ERR_RECORD;
                        end else begin
                            param_ok_next = param_ok_reg | sel;
                            action_next = CPD_ACT_RESTORE;
                        end
                    end
                    `CPD_CMD_DEFAULTS: begin
                        if (sel_none) begin
                            err_next = `CPD_ERR_NO_SEL;
                        end else begin
                            param_ok_next = param_ok_reg | sel;
                            action_next = CPD_ACT_DEFAULTS;
                        end
                    end
                    `CPD_CMD_FAST_REPARAM: begin
                        if (sel_none) begin
                            err_next = `CPD_ERR_NO_SEL;
                        end else begin
                            param_ok_next = param_ok_reg | sel;
                            fast_next = 1'b1;
                            action_next = CPD_ACT_FAST;
                        end
                    end
                    `CPD_CMD_READ_BACK: begin
                        if (sel_none) begin
                            err_next = `CPD_ERR_NO_SEL;
                        end else begin
                            action_next = CPD_ACT_READ_BACK;
                        end
                    end
                    `CPD_CMD_WRITE_REGS: begin
                        if (sel_none) begin
                            err_next = `CPD_ERR_NO_SEL;
                        end else begin
                            action_next = CPD_ACT_WRITE_REGS;
                        end
                    end
                    `CPD_CMD_SELF_TEST: begin
                        // the host keeps this out of lists; refused there anyway
                        if (i_in_list) begin
                            err_next = `CPD_ERR_TEST_BITS;
                        end else if (|sel[7:5]) begin
                            err_next = `CPD_ERR_TEST_BITS;
                        end else if (sel_none) begin
                            err_next = `CPD_ERR_NO_SEL;
                        end else begin
                            action_next = CPD_ACT_TEST;
                            test_fault_next = test_hit;
                            if (|test_hit) begin
                                err_next       = test_code;
                                group_err_next = 1'b1;
                                red_next       = 1'b1;
                            end
                        end
                    end
                    `CPD_CMD_RUN_LISTS: begin
                        if (sel_none || sel[0]) begin
                            err_next = `CPD_ERR_NO_SEL;
                        end else begin
                            list_pend_next  = sel;
                            list_trace_next = 8'h00;
                            state_next      = ST_LISTS;
                        end
                    end
                    `CPD_CMD_READ_SERIES: begin
                        if (sel_none) begin
                            err_next = `CPD_ERR_NO_SEL;
                        end else if (|dir_miss) begin
                            err_next = dir_first;
                        end else begin
                            // fill pointer and full status are left alone
                            action_next = CPD_ACT_SERIES;
                        end
                    end
                    default: begin
                        // unknown codes are ignored and leave the log as it is
                        action_next = CPD_ACT_NONE;
                    end
                endcase
            end
            ST_LISTS: begin
                // lowest list number first, one per cycle
                action_next     = CPD_ACT_LIST;
                list_trace_next = list_trace_reg | list_low;
                list_pend_next  = list_pend_reg & ~list_low;
                if ((list_pend_reg & ~list_low) == 8'h00) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg      <= ST_IDLE;
            cw_reg         <= '0;
            action_reg     <= CPD_ACT_NONE;
            err_reg        <= `CPD_ERR_NONE;
            rec_sel_reg    <= 8'h00;
            rec_stored_reg <= 8'h00;
            test_fault_reg <= 5'h00;
            dir_valid_reg  <= 8'h00;
            param_ok_reg   <= 8'h00;
            list_pend_reg  <= 8'h00;
            list_trace_reg <= 8'h00;
            group_err_reg  <= 1'b0;
            red_reg        <= 1'b0;
            fast_reg       <= 1'b0;
        end else begin
            state_reg      <= state_next;
            action_reg     <= action_next;
            err_reg        <= err_next;
            rec_stored_reg <= rec_stored_next;
            test_fault_reg <= test_fault_next;
            param_ok_reg   <= param_ok_next;
            list_pend_reg  <= list_pend_next;
            list_trace_reg <= list_trace_next;
            group_err_reg  <= group_err_next;
            red_reg        <= red_next;
            fast_reg       <= fast_next;
            if (new_cmd) begin
                cw_reg <= i_avs_writedata[15:0];
            end
            if (wr_rec) begin
                rec_sel_reg <= i_avs_writedata[7:0];
            end
            if (wr_dir) begin
                dir_valid_reg <= i_avs_writedata[7:0];
            end
        end
    end

    cpd_flash_div #(
        .CYCLES (FLASH_CYCLES)
    ) u_flash (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .o_tick    (flash_tick)
    );

    // green flashes while parameters are incomplete, dark after a test fault
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            green_reg <= 1'b0;
        end else if (red_next) begin
            // next-state red so both leds switch on the same edge
            green_reg <= 1'b0;
        end else if (fast_reg) begin
            green_reg <= 1'b0;
        end else if (params_good) begin
            green_reg <= 1'b1;
        end else if (flash_tick) begin
            green_reg <= ~green_reg;
        end
    end

    // read selection kept out of the flop so the register process stays small
    logic [31:0] rd_mux;
    always_comb begin
        case (i_avs_address)
            `CPD_OFF_CTRL_WORD:  rd_mux = {16'h0000, cw_reg};
            `CPD_OFF_ERR_INFO:   rd_mux = {24'h000000, err_reg};
            `CPD_OFF_STATUS:     rd_mux = {27'h0000000, status_bits};
            `CPD_OFF_RECORD_SEL: rd_mux = {24'h000000, rec_sel_reg};
            `CPD_OFF_TEST_FAULT: rd_mux = {27'h0000000, test_fault_reg};
            `CPD_OFF_DIR_VALID:  rd_mux = {24'h000000, dir_valid_reg};
            `CPD_OFF_PARAM_OK:   rd_mux = {24'h000000, param_ok_reg};
            `CPD_OFF_ACTION:     rd_mux = {28'h0000000, action_reg};
            `CPD_OFF_LIST_TRACE: rd_mux = {24'h000000, list_trace_reg};
            default:             rd_mux = 32'h0000_0000;
        endcase
    end

    // one wait cycle per access, more for a control word written while busy; ack_reg drops waitrequest
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ack_reg        <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
        end else begin
            ack_reg <= take & ~ctrl_hold;
            if (rd_take) begin
                o_avs_readdata <= rd_mux;
            end
        end
    end

    assign o_avs_waitrequest = take;
    assign o_led_green       = green_reg;
    assign o_led_red         = red_reg;
    assign o_test_load_value = `CPD_TEST_LOAD_VALUE;
    assign o_test_count_down = (action_reg == CPD_ACT_TEST);
endmodule

// *** cpd_decoder_props.sv ***
`timescale 1ns/100ps
module cpd_decoder_props #(
    parameter int unsigned FLASH_CYCLES = 4
) (
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic [7:0]  i_avs_address,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0]  i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic [4:0]  i_test_fail,
    input wire logic        i_in_list,
    input wire logic        o_led_green,
    input wire logic        o_led_red,
    input wire logic [15:0] o_test_load_value,
    input wire logic        o_test_count_down
);
    logic [31:0] off_cnt_reg;

    // a dark run led longer than one flash phase means the divider or the mux is stuck
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || o_led_green || o_led_red) begin
            off_cnt_reg <= 32'h0;
        end else begin
            off_cnt_reg <= off_cnt_reg + 32'h1;
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_flash; off_cnt_reg <= FLASH_CYCLES + 2; endproperty
    a_flash: assert property (p_flash) else $error("run led dark too long");
    property p_red_hold; o_led_red |=> o_led_red; endproperty
    a_red_hold: assert property (p_red_hold) else $error("red led dropped");
    property p_red_green; o_led_red |-> !o_led_green; endproperty
    a_red_green: assert property (p_red_green) else $error("green on with red");
    property p_load; o_test_load_value == 16'hFFFF; endproperty
    a_load: assert property (p_load) else $error("test load value wrong");
    property p_cd_pulse; o_test_count_down |=> !o_test_count_down; endproperty
    a_cd_pulse: assert property (p_cd_pulse) else $error("count down not a pulse");
    property p_rd_wait;
        i_avs_read && !$past(i_avs_read) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read answer late");
    property p_idle; !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest; endproperty
    a_idle: assert property (p_idle) else $error("wait without request");
    property p_wr_done; $rose(i_avs_write) |-> ##[1:40] !o_avs_waitrequest; endproperty
    a_wr_done: assert property (p_wr_done) else $error("write never taken");

    c_red: cover property ($rose(o_led_red));
    c_cd: cover property (o_test_count_down);
    c_wr: cover property (i_avs_write && !o_avs_waitrequest);
endmodule

bind cpd_decoder cpd_decoder_props #(.FLASH_CYCLES(FLASH_CYCLES)) cpd_decoder_props_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_test_fail(i_test_fail),
    .i_in_list(i_in_list), .o_led_green(o_led_green), .o_led_red(o_led_red),
    .o_test_load_value(o_test_load_value), .o_test_count_down(o_test_count_down)
);

// *** cpd_flash_div.sv ***
`timescale 1ns/100ps
`include "cpd_cfg.svh"
// free-running divider giving a one-cycle tick at each flash half period
module cpd_flash_div #(
    parameter int unsigned CYCLES = `CPD_FLASH_CYCLES
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    output logic      o_tick
);
    logic [31:0] cnt_reg;
    wire         wrap = (cnt_reg == 32'(CYCLES - 1));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || wrap) begin
            cnt_reg <= 32'h0000_0000;
        end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
        end
    end

    assign o_tick = wrap;
endmodule

// *** cpd_host_model.sv ***
`timescale 1ns/100ps
`include "cpd_cfg.svh"
module cpd_host_model import cpd_pkg::*; (
    input  wire logic        i_clk_sys,
    input  wire logic [31:0] i_readdata,
    input  wire logic        i_waitrequest,
    output logic [7:0]       o_address,
    output logic             o_read,
    output logic             o_write,
    output logic [31:0]      o_writedata,
    output logic [3:0]       o_byteenable
);
    initial begin
        o_address = 8'h00;
        o_read = 1'b0;
        o_write = 1'b0;
        o_writedata = 32'h0;
        o_byteenable = 4'hF;
    end

    // request held until waitrequest low is seen; only the bench timeout ends a wait
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge i_clk_sys);
        o_address <= a;
        o_writedata <= d;
        o_read <= !w;
        o_write <= w;
        @(posedge i_clk_sys);
        while (i_waitrequest !== 1'b0) @(posedge i_clk_sys);
        q = i_readdata;
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask

    // clears the error log first so each command is judged alone
    task automatic cmd(input logic [7:0] code, input logic [7:0] sel);
        cpd_ctrl_word_t cw;
        logic [31:0]    q;
        cw = '{code, sel};
        xfer(`CPD_OFF_ERR_INFO, 1'b1, 32'h0, q);
        xfer(`CPD_OFF_CTRL_WORD, 1'b1, {16'h0, cw}, q);
        q = 32'h1;
        while (q[`CPD_ST_BUSY] !== 1'b0) xfer(`CPD_OFF_STATUS, 1'b0, 32'h0, q);
    endtask
endmodule

// *** cpd_pkg.sv ***
package cpd_pkg;
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] sel;
    } cpd_ctrl_word_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       read;
        logic       write;
        logic [31:0] wdata;
    } cpd_bus_req_t;

    typedef enum logic [3:0] {
        CPD_ACT_NONE,
        CPD_ACT_STORE,
        CPD_ACT_RESTORE,
        CPD_ACT_DEFAULTS,
        CPD_ACT_FAST,
        CPD_ACT_READ_BACK,
        CPD_ACT_WRITE_REGS,
        CPD_ACT_TEST,
        CPD_ACT_LIST,
        CPD_ACT_SERIES
    } cpd_action_t;
endpackage

// *** tb_top.sv ***
`timescale 1ns/100ps
`include "cpd_cfg.svh"
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic [31:0] q;
    logic [3:0]  byteenable;
    logic        waitrequest;
    logic        green;
    logic        red;
    logic        cdown;
    logic [15:0] load_value;
    logic [4:0]  test_fail = 5'h00;
    logic        in_list = 1'b0;
    logic [7:0]  codes [9] = '{8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77, 8'h81, 8'h82, 8'h83};
    int          n_fail = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n_cd = 0;

    always #50 clk = ~clk;

    cpd_decoder #(.FLASH_CYCLES(4), .EXTENDED(1'b1)) cpd_decoder_inst (
        .i_clk_sys(clk), .i_rst(rst), .i_avs_address(address), .i_avs_read(read),
        .i_avs_write(write), .i_avs_writedata(writedata), .i_avs_byteenable(byteenable),
        .o_avs_readdata(readdata), .o_avs_waitrequest(waitrequest), .i_test_fail(test_fail),
        .i_in_list(in_list), .o_led_green(green), .o_led_red(red),
        .o_test_load_value(load_value), .o_test_count_down(cdown)
    );
    cpd_host_model cpd_host_model_inst (
        .i_clk_sys(clk), .i_readdata(readdata), .i_waitrequest(waitrequest),
        .o_address(address), .o_read(read), .o_write(write), .o_writedata(writedata),
        .o_byteenable(byteenable)
    );

    task automatic test_done();
        if (n_fail == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cdown === 1'b1) n_cd++;
        if (cyc == 30000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cpd_host_model_inst.xfer(a, 1'b1, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        cpd_host_model_inst.xfer(a, 1'b0, 32'h0, q);
        chk_reg(q, exp);
    endtask
    task automatic cmd_err(input logic [7:0] code, input logic [7:0] sel, input logic [7:0] e);
        cpd_host_model_inst.cmd(code, sel);
        rd_chk(`CPD_OFF_ERR_INFO, {24'h0, e});
    endtask

    task automatic do_reset();
        repeat (5) @(posedge clk);
        chk_bit(green, 1'b0);
        chk_bit(red, 1'b0);
        rst <= 1'b0;
    endtask

    task automatic t_basic();
        rd_chk(`CPD_OFF_ERR_INFO, 32'h0);
        wr(8'hF0, 32'hFFFF_FFFF);
        rd_chk(8'hF0, 32'h0);
        for (int i = 0; i < 9; i++) cmd_err(codes[i], 8'h00, `CPD_ERR_NO_SEL);
    endtask

    task automatic t_flash();
        int   tog;
        int   off;
        logic g0;
        tog = 0;
        off = 0;
        g0 = green;
        repeat (40) begin
            @(negedge clk);
            if (green !== g0) tog++;
            g0 = green;
        end
        chk_bit(tog >= 8, 1'b1);
        for (int i = 0; i < 6; i++) cmd_err(codes[i], 8'hFF, 8'h00);
        repeat (20) begin
            @(negedge clk);
            if (green !== 1'b1) off++;
        end
        chk_reg(32'(off), 32'h0);
        rd_chk(`CPD_OFF_PARAM_OK, 32'hFF);
    endtask

    task automatic t_record();
        wr(`CPD_OFF_RECORD_SEL, 32'h3);
        cmd_err(8'h73, 8'h94, `CPD_ERR_RECORD);
        wr(`CPD_OFF_RECORD_SEL, 32'h8);
        cmd_err(8'h72, 8'hFF, `CPD_ERR_RECORD);
        cmd_err(8'h73, 8'hFF, `CPD_ERR_RECORD);
        cmd_err(8'h72, 8'h00, `CPD_ERR_NO_SEL);
        wr(`CPD_OFF_RECORD_SEL, 32'h7);
        cmd_err(8'h72, 8'hFF, 8'h00);
        cmd_err(8'h73, 8'h94, 8'h00);
    endtask

    task automatic t_lists_series();
        cmd_err(8'h82, 8'h01, `CPD_ERR_NO_SEL);
        cmd_err(8'h82, 8'h25, `CPD_ERR_NO_SEL);
        cmd_err(8'h82, 8'h24, 8'h00);
        rd_chk(`CPD_OFF_LIST_TRACE, 32'h24);
        wr(`CPD_OFF_DIR_VALID, 32'h0);
        cmd_err(8'h83, 8'h98, 8'h43);
        cmd_err(8'h83, 8'h01, 8'h00);
        wr(`CPD_OFF_DIR_VALID, 32'hFF);
        cmd_err(8'h83, 8'h98, 8'h00);
    endtask

    task automatic t_test();
        int n0;
        cmd_err(8'h81, 8'h20, `CPD_ERR_TEST_BITS);
        cmd_err(8'h81, 8'h81, `CPD_ERR_TEST_BITS);
        in_list <= 1'b1;
        cmd_err(8'h81, 8'h01, `CPD_ERR_TEST_BITS);
        in_list <= 1'b0;
        n0 = n_cd;
        cmd_err(8'h81, 8'h1F, 8'h00);
        chk_reg(32'(n_cd - n0), 32'h1);
        chk_bit(red, 1'b0);
        for (int i = 0; i < 5; i++) begin
            test_fail <= 5'(1 << i);
            cmd_err(8'h81, 8'(1 << i), 8'(5 + i));
        end
        test_fail <= 5'h00;
        chk_bit(red, 1'b1);
        chk_bit(green, 1'b0);
        cpd_host_model_inst.xfer(`CPD_OFF_STATUS, 1'b0, 32'h0, q);
        chk_reg(q & 32'hF, 32'hC);
        chk_reg({16'h0, load_value}, 32'hFFFF);
        rd_chk(`CPD_OFF_TEST_FAULT, 32'h10);
    endtask

    initial begin
        do_reset();
        t_basic();
        t_flash();
        t_record();
        t_lists_series();
        t_test();
        test_done();
    end
endmodule
